/* File: logic/flash_cmd_defines.vh */
// constants for the flash command front end and query table
// Function
// - wrong address, data or order in a sequence returns to array read
// - command address taken when the later of strobe and select falls
// - command data taken when the earlier of strobe and select rises
// - after power-up the device reads the array with no command
// - finished embedded program or erase returns to array read
// - accepted erase suspend enters suspended mode with array reads allowed
// - suspended-sector reads give status, other reads give array data except while a program runs
// - program finished during suspend keeps the suspended-sector status rule
// - erase suspend capability entry reads 0002h
// - sector protect group size entry reads 0001h
// - temporary unprotect entry reads 0000h, burst read entry 0001h
// - protection scheme entry reads 0006h
// - concurrent operation sector count entry reads 001Fh
// - page read type entry reads 0000h
// - accel supply minimum reads 00B5h and maximum 00C5h
// - boot sector layout flag entry reads 0001h
// - bank count entry reads 0002h
// - bank sector counts read 000Fh, 001Fh, 0000h, 0000h
// - extended block starts with ASCII P, R, I at 40h to 42h
`ifndef FLASH_CMD_DEFINES_VH
`define FLASH_CMD_DEFINES_VH

// query offsets (32-bit mode word offsets)
`define Q_TAG_P            8'h40
`define Q_TAG_R            8'h41
`define Q_TAG_I            8'h42
`define Q_VER_MAJOR        8'h43
`define Q_VER_MINOR        8'h44
`define Q_UNLOCK_REV       8'h45
`define Q_ERASE_SUSP_CAP   8'h46
`define Q_PROT_GROUP       8'h47
`define Q_TEMP_UNPROT      8'h48
`define Q_PROT_SCHEME      8'h49
`define Q_CONC_SECTORS     8'h4A
`define Q_BURST_SUPPORT    8'h4B
`define Q_PAGE_TYPE        8'h4C
`define Q_ACCEL_MIN        8'h4D
`define Q_ACCEL_MAX        8'h4E
`define Q_BOOT_LAYOUT      8'h4F
`define Q_PROG_SUSP        8'h50
`define Q_WBUF_EXP         8'h51
`define Q_BANK_COUNT       8'h57
`define Q_BANK1_SECTORS    8'h58
`define Q_BANK2_SECTORS    8'h59
`define Q_BANK3_SECTORS    8'h5A
`define Q_BANK4_SECTORS    8'h5B

// query values
`define V_TAG_P            16'h0050
`define V_TAG_R            16'h0052
`define V_TAG_I            16'h0049
`define V_VER_MAJOR        16'h0031
`define V_VER_MINOR        16'h0033
`define V_UNLOCK_REV       16'h0004
`define V_ERASE_SUSP_CAP   16'h0002
`define V_PROT_GROUP       16'h0001
`define V_TEMP_UNPROT      16'h0000
`define V_PROT_SCHEME      16'h0006
`define V_CONC_SECTORS     16'h001F
`define V_BURST_SUPPORT    16'h0001
`define V_PAGE_TYPE        16'h0000
`define V_ACCEL_MIN        16'h00B5
`define V_ACCEL_MAX        16'h00C5
`define V_BOOT_LAYOUT      16'h0001
`define V_PROG_SUSP        16'h0001
`define V_WBUF_EXP         16'h0000
`define V_BANK_COUNT       16'h0002
`define V_BANK1_SECTORS    16'h000F
`define V_BANK2_SECTORS    16'h001F
`define V_BANK3_SECTORS    16'h0000
`define V_BANK4_SECTORS    16'h0000

// command cycle addresses (low 11 address bits) and codes
`define UNLOCK_ADDR1       11'h555
`define UNLOCK_ADDR2       11'h2AA
`define QUERY_ADDR         11'h055
`define CMD_UNLOCK1        8'hAA
`define CMD_UNLOCK2        8'h55
`define CMD_PROGRAM        8'hA0
`define CMD_ERASE_SETUP    8'h80
`define CMD_SECTOR_ERASE   8'h30
`define CMD_AUTOSELECT     8'h90
`define CMD_QUERY          8'h98
`define CMD_RESET          8'hF0
`define CMD_SUSPEND        8'hB0
`define CMD_RESUME         8'h30

// status word bit positions
`define ST_BIT_POLL        7
`define ST_BIT_TOGGLE      6
`define ST_BIT_ERROR       5
`define ST_BIT_SUSP_TOG    2

`endif

/* File: logic/flash_cmd_front.v */
// command entry, read-mode control and query table of the flash front end
`timescale 1ns/1ns
`include "flash_cmd_defines.vh"

module flash_cmd_front #(
  parameter ADDR_W    = 20,                  // word address width
  parameter SEC_SHIFT = 15                   // address bits inside a sector
) (
  input  wire              i_ref_clk,        // 100 MHz core clock
  input  wire              i_resetn,         // power-up reset, active low
  input  wire              i_ce_n,           // chip select pin
  input  wire              i_we_n,           // write strobe pin
  input  wire              i_oe_n,           // output enable pin
  input  wire              i_bus32,          // 1 = 32-bit bus, 0 = 16-bit
  input  wire [ADDR_W-1:0] i_addr,           // address pins
  input  wire [31:0]       i_dq,             // data pins, input side
  output reg  [31:0]       o_dq,             // data pins, output side
  output reg               o_dq_oe,          // data pins driven
  input  wire [31:0]       i_array_data,     // array core read data
  input  wire              i_core_done,      // array core finished operation
  input  wire              i_core_fail,      // array core operation failed
  output reg  [ADDR_W-1:0] o_array_addr,     // address to the array core
  output reg               o_prog_req,       // program start pulse
  output reg               o_erase_req,      // sector erase start pulse
  output reg               o_suspend_req,    // erase suspend pulse
  output reg               o_resume_req,     // erase resume pulse
  output reg  [31:0]       o_prog_data,      // program data
  output reg               o_erase_susp      // erase suspended mode
);

  localparam [3:0] S_READ  = 4'h0;
  localparam [3:0] S_UNLK1 = 4'h1;
  localparam [3:0] S_UNLK2 = 4'h2;
  localparam [3:0] S_PROG  = 4'h3;
  localparam [3:0] S_EUNL0 = 4'h4;
  localparam [3:0] S_EUNL1 = 4'h5;
  localparam [3:0] S_EUNL2 = 4'h6;
  localparam [3:0] S_BPROG = 4'h7;
  localparam [3:0] S_BERAS = 4'h8;
  localparam [3:0] S_QUERY = 4'h9;
  localparam [3:0] S_ASEL  = 4'hA;
  localparam [3:0] S_FAIL  = 4'hB;

  localparam SEC_W = ADDR_W - SEC_SHIFT;

  // reset release
  reg rst_m_q;
  reg rst_n_q;
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_m_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n_q <= rst_m_q;
    end
  end

  // pin synchronisers
  reg [2:0]        ctl_m_q;
  reg [2:0]        ctl_s_q;
  reg              b32_m_q;
  reg              b32_s_q;
  reg [ADDR_W-1:0] adr_m_q;
  reg [ADDR_W-1:0] adr_s_q;
  reg [31:0]       dq_m_q;
  reg [31:0]       dq_s_q;
  always @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_m_q <= 3'h7;
      ctl_s_q <= 3'h7;
      b32_m_q <= 1'b0;
      b32_s_q <= 1'b0;
      adr_m_q <= {ADDR_W{1'b0}};
      adr_s_q <= {ADDR_W{1'b0}};
      dq_m_q  <= 32'h00000000;
      dq_s_q  <= 32'h00000000;
    end else begin
      ctl_m_q <= {i_oe_n, i_we_n, i_ce_n};
      ctl_s_q <= ctl_m_q;
      b32_m_q <= i_bus32;
      b32_s_q <= b32_m_q;
      adr_m_q <= i_addr;
      adr_s_q <= adr_m_q;
      dq_m_q  <= i_dq;
      dq_s_q  <= dq_m_q;
    end
  end

  wire wr_act = ~ctl_s_q[0] & ~ctl_s_q[1];
  wire rd_act = ~ctl_s_q[0] & ~ctl_s_q[2] & ctl_s_q[1];

  reg              wr_act_q;
  reg              rd_act_q;
  reg [ADDR_W-1:0] cmd_addr_q;
  always @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_act_q   <= 1'b0;
      rd_act_q   <= 1'b0;
      cmd_addr_q <= {ADDR_W{1'b0}};
    end else begin
      wr_act_q <= wr_act;
      rd_act_q <= rd_act;
      if (wr_act && !wr_act_q)
        cmd_addr_q <= adr_s_q;
    end
  end

  // data taken when the write window closes, i.e. first rising pin
  wire       wr_end  = wr_act_q & ~wr_act;
  wire [7:0] wr_data = dq_s_q[7:0];
  wire [10:0] wa     = cmd_addr_q[10:0];
  wire [SEC_W-1:0] wsec = cmd_addr_q[ADDR_W-1:SEC_SHIFT];
  wire [SEC_W-1:0] rsec = adr_s_q[ADDR_W-1:SEC_SHIFT];
  wire is_unlk1 = (wa == `UNLOCK_ADDR1) && (wr_data == `CMD_UNLOCK1);
  wire is_unlk2 = (wa == `UNLOCK_ADDR2) && (wr_data == `CMD_UNLOCK2);
  wire is_reset = (wr_data == `CMD_RESET);

  // query offset: word offset in 32-bit mode, half the address in 16-bit
  wire [7:0] q_off = b32_s_q ? adr_s_q[7:0] : adr_s_q[8:1];

  function [15:0] query_value;
    input [7:0] off;
    begin
      case (off)
        `Q_TAG_P:          query_value = `V_TAG_P;
        `Q_TAG_R:          query_value = `V_TAG_R;
        `Q_TAG_I:          query_value = `V_TAG_I;
        `Q_VER_MAJOR:      query_value = `V_VER_MAJOR;
        `Q_VER_MINOR:      query_value = `V_VER_MINOR;
        `Q_UNLOCK_REV:     query_value = `V_UNLOCK_REV;
        `Q_ERASE_SUSP_CAP: query_value = `V_ERASE_SUSP_CAP;
        `Q_PROT_GROUP:     query_value = `V_PROT_GROUP;
        `Q_TEMP_UNPROT:    query_value = `V_TEMP_UNPROT;
        `Q_PROT_SCHEME:    query_value = `V_PROT_SCHEME;
        `Q_CONC_SECTORS:   query_value = `V_CONC_SECTORS;
        `Q_BURST_SUPPORT:  query_value = `V_BURST_SUPPORT;
        `Q_PAGE_TYPE:      query_value = `V_PAGE_TYPE;
        `Q_ACCEL_MIN:      query_value = `V_ACCEL_MIN;
        `Q_ACCEL_MAX:      query_value = `V_ACCEL_MAX;
        `Q_BOOT_LAYOUT:    query_value = `V_BOOT_LAYOUT;
        `Q_PROG_SUSP:      query_value = `V_PROG_SUSP;
        `Q_WBUF_EXP:       query_value = `V_WBUF_EXP;
        `Q_BANK_COUNT:     query_value = `V_BANK_COUNT;
        `Q_BANK1_SECTORS:  query_value = `V_BANK1_SECTORS;
        `Q_BANK2_SECTORS:  query_value = `V_BANK2_SECTORS;
        `Q_BANK3_SECTORS:  query_value = `V_BANK3_SECTORS;
        `Q_BANK4_SECTORS:  query_value = `V_BANK4_SECTORS;
        default:           query_value = 16'h0000;
      endcase
    end
  endfunction

  reg [3:0]       state_q;
  reg [3:0]       state_d;
  reg             susp_q;
  reg [SEC_W-1:0] susp_sec_q;
  reg [SEC_W-1:0] ers_sec_q;
  reg             err_q;
  reg             tog_q;
  reg             stog_q;

  wire busy = (state_q == S_BPROG) || (state_q == S_BERAS) ||
              (state_q == S_FAIL);

  // command sequencer; an unexpected cycle falls back to array read, except in program and erase (held) and fail (held until reset)
  always @* begin
    state_d = state_q;
    if (wr_end) begin
      case (state_q)
        S_READ, S_QUERY, S_ASEL: begin
          if (is_unlk1 && state_q == S_READ)
            state_d = S_UNLK1;
          else if (wr_data == `CMD_QUERY && wa == `QUERY_ADDR)
            state_d = S_QUERY;
          else if (susp_q && wr_data == `CMD_RESUME && state_q == S_READ)
            state_d = S_BERAS;
          else
            state_d = S_READ;
        end
        S_UNLK1: state_d = is_unlk2 ? S_UNLK2 : S_READ;
        S_UNLK2: begin
          if (wa == `UNLOCK_ADDR1 && wr_data == `CMD_PROGRAM)
            state_d = S_PROG;
          else if (wa == `UNLOCK_ADDR1 && wr_data == `CMD_ERASE_SETUP &&
                   !susp_q)
            state_d = S_EUNL0;
          else if (wa == `UNLOCK_ADDR1 && wr_data == `CMD_AUTOSELECT)
            state_d = S_ASEL;
          else
            state_d = S_READ;
        end
        S_PROG:  state_d = S_BPROG;
        S_EUNL0: state_d = is_unlk1 ? S_EUNL1 : S_READ;
        S_EUNL1: state_d = is_unlk2 ? S_EUNL2 : S_READ;
        S_EUNL2: state_d = (wr_data == `CMD_SECTOR_ERASE) ? S_BERAS
                                                          : S_READ;
        S_BERAS: state_d = (wr_data == `CMD_SUSPEND) ? S_READ
                                                     : S_BERAS;
        S_FAIL:  state_d = is_reset ? S_READ : S_FAIL;
        default: state_d = state_q;
      endcase
    end else if (i_core_fail && (state_q == S_BPROG ||
                                 state_q == S_BERAS)) begin
      state_d = S_FAIL;
    end else if (i_core_done && (state_q == S_BPROG ||
                                 state_q == S_BERAS)) begin
      state_d = S_READ;
    end
  end

  always @(posedge i_ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q       <= S_READ;
      susp_q        <= 1'b0;
      susp_sec_q    <= {SEC_W{1'b0}};
      ers_sec_q     <= {SEC_W{1'b0}};
      err_q         <= 1'b0;
      tog_q         <= 1'b0;
      stog_q        <= 1'b0;
      o_prog_req    <= 1'b0;
      o_erase_req   <= 1'b0;
      o_suspend_req <= 1'b0;
      o_resume_req  <= 1'b0;
      o_prog_data   <= 32'h00000000;
      o_array_addr  <= {ADDR_W{1'b0}};
      o_erase_susp  <= 1'b0;
      o_dq          <= 32'h00000000;
      o_dq_oe       <= 1'b0;
    end else begin
      state_q       <= state_d;
      o_prog_req    <= 1'b0;
      o_erase_req   <= 1'b0;
      o_suspend_req <= 1'b0;
      o_resume_req  <= 1'b0;
      if (wr_end && state_q == S_PROG) begin
        o_prog_req   <= 1'b1;
        o_prog_data  <= dq_s_q;
        o_array_addr <= cmd_addr_q;
      end else if (wr_end && state_q == S_EUNL2 &&
                   wr_data == `CMD_SECTOR_ERASE) begin
        o_erase_req  <= 1'b1;
        ers_sec_q    <= wsec;
        o_array_addr <= cmd_addr_q;
      end else if (rd_act) begin
        o_array_addr <= adr_s_q;
      end
      if (wr_end && state_q == S_BERAS && wr_data == `CMD_SUSPEND) begin
        susp_q        <= 1'b1;
        susp_sec_q    <= ers_sec_q;
        o_suspend_req <= 1'b1;
      end else if (state_d == S_BERAS && state_q == S_READ) begin
        susp_q       <= 1'b0;
        o_resume_req <= 1'b1;
      end else if (state_q == S_BERAS && state_d == S_READ) begin
        susp_q <= 1'b0;
      end
      o_erase_susp <= susp_q;
      // error flag: a reset write in the same cycle as a failure wins, and the failure is dropped
      if (state_d == S_FAIL)
        err_q <= 1'b1;
      else if (wr_end && is_reset)
        err_q <= 1'b0;
      if (rd_act && !rd_act_q) begin
        tog_q <= ~tog_q;
        if (susp_q && rsec == susp_sec_q)
          stog_q <= ~stog_q;
      end
      o_dq_oe <= rd_act;
      if (busy) begin
        o_dq <= 32'h00000000;
        o_dq[`ST_BIT_TOGGLE] <= tog_q;
        o_dq[`ST_BIT_ERROR]  <= err_q;
        o_dq[`ST_BIT_POLL]   <= ~i_array_data[`ST_BIT_POLL];
      end else if (state_q == S_QUERY) begin
        o_dq <= {16'h0000, query_value(q_off)};
      end else if (susp_q && rsec == susp_sec_q) begin
        o_dq <= 32'h00000000;
        o_dq[`ST_BIT_POLL]     <= 1'b1;
        o_dq[`ST_BIT_SUSP_TOG] <= stog_q;
      end else begin
        o_dq <= i_array_data;
      end
    end
  end

endmodule // flash_cmd_front

/* File: verif/flash_cmd_front_assertions.sv */
// port checker for the flash command front end
`timescale 1ns/1ns
module flash_cmd_front_checker (
  input wire i_ref_clk,     // core clock
  input wire i_resetn,      // power-up reset
  input wire i_ce_n,        // chip select pin
  input wire i_we_n,        // write strobe pin
  input wire i_oe_n,        // output enable pin
  input wire o_dq_oe,       // data pins driven
  input wire o_prog_req,    // program start
  input wire o_erase_req,   // erase start
  input wire o_suspend_req, // erase suspend
  input wire o_resume_req,  // erase resume
  input wire o_erase_susp   // suspended mode
);
  reg [5:0] rd_hist_q;
  reg       started_q = 1'b0;

  // outputs are unknown until the first edge in reset has cleared them
  always @(posedge i_ref_clk) begin
    started_q <= 1'b1;
  end

  // recent cycles with a read cycle on the pins
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_hist_q <= 6'h00;
    end else begin
      rd_hist_q <= {rd_hist_q[4:0], !i_ce_n && !i_oe_n && i_we_n};
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  a_reset_quiet: assert property (disable iff (1'b0)
    (!i_resetn && started_q) |->
    !(o_prog_req || o_erase_req || o_dq_oe || o_erase_susp))
    else $error("outputs active during reset");
  a_read_drives_bus: assert property ((&rd_hist_q) |-> o_dq_oe)
    else $error("read cycle not answered");
  a_drive_needs_read: assert property (o_dq_oe |-> (|rd_hist_q))
    else $error("data pins driven without a read");
  a_prog_after_rise: assert property (o_prog_req |->
    $past(i_we_n) && $past(i_we_n, 2))
    else $error("program started before the strobe rose");
  a_prog_single_pulse: assert property (o_prog_req |=> !o_prog_req)
    else $error("program request longer than one cycle");
  a_erase_single_pulse: assert property (o_erase_req |=> !o_erase_req)
    else $error("erase request longer than one cycle");
  a_one_request: assert property ($onehot0({o_prog_req, o_erase_req,
    o_suspend_req, o_resume_req}))
    else $error("two requests at once");
  a_suspend_enters: assert property (
    o_suspend_req |-> ##[0:3] o_erase_susp)
    else $error("suspend not entered");
  a_resume_leaves: assert property (
    o_resume_req |-> ##[0:3] !o_erase_susp)
    else $error("suspend not left on resume");
endmodule // flash_cmd_front_checker

bind flash_cmd_front flash_cmd_front_checker i_chk (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce_n(i_ce_n),
  .i_we_n(i_we_n), .i_oe_n(i_oe_n), .o_dq_oe(o_dq_oe),
  .o_prog_req(o_prog_req), .o_erase_req(o_erase_req),
  .o_suspend_req(o_suspend_req), .o_resume_req(o_resume_req),
  .o_erase_susp(o_erase_susp)
);

/* File: verif/flash_host_model.sv */
// host bus master that runs write and read cycles on the flash pins
`timescale 1ns/1ns
module flash_host_model (
  input  wire        i_clk,   // bench clock
  input  wire [31:0] i_dq,    // resolved data pins
  output reg         o_ce_n,  // chip select
  output reg         o_we_n,  // write strobe
  output reg         o_oe_n,  // output enable
  output reg         o_bus32, // bus width select
  output reg  [19:0] o_addr,  // address pins
  output reg  [31:0] o_dq     // data driven on writes
);
  initial begin
    {o_ce_n, o_we_n, o_oe_n, o_bus32} = 4'hF;
    o_addr = 20'h00000;
    o_dq = 32'h00000000;
  end

  task wr(input [19:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_dq <= d;
      repeat (2) @(posedge i_clk);
      o_ce_n <= 1'b0;
      o_we_n <= 1'b0; // address taken at the later fall
      repeat (6) @(posedge i_clk);
      o_we_n <= 1'b1; // data taken at the first rise
      repeat (2) @(posedge i_clk);
      o_ce_n <= 1'b1;
      repeat (6) @(posedge i_clk);
      o_dq <= ~d; // hold over: bus no longer shows the old value
    end
  endtask

  task rd(input [19:0] a, output [31:0] d);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_ce_n <= 1'b0;
      o_oe_n <= 1'b0;
      repeat (8) @(posedge i_clk);
      d = i_dq;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      repeat (5) @(posedge i_clk);
    end
  endtask

  task width(input b);
    begin
      @(posedge i_clk);
      o_bus32 <= b;
      repeat (4) @(posedge i_clk);
    end
  endtask
endmodule // flash_host_model

/* File: verif/flash_cmd_front_test.sv */
// self-checking bench for the flash command front end
`timescale 1ns/1ns
module flash_cmd_front_test;
  reg         i_ref_clk = 1'b0;
  reg         i_resetn = 1'b0;
  reg  [31:0] i_array_data = 32'h00000000;
  reg         i_core_done = 1'b0;
  reg         i_core_fail = 1'b0;
  wire        ce_n, we_n, oe_n, bus32, o_dq_oe, o_erase_susp;
  wire        o_prog_req, o_erase_req, o_suspend_req, o_resume_req;
  wire [19:0] addr, o_array_addr;
  wire [31:0] h_dq, o_dq, o_prog_data;
  wire [31:0] dq_w = o_dq_oe ? o_dq : h_dq;
  integer     mismatches = 0, tests_run = 0, i, m;
  integer     n_prog = 0, n_erase = 0, n_susp = 0, n_res = 0;
  reg  [19:0] prog_addr = 20'h00000;
  reg  [31:0] prog_data = 32'h00000000, rv, rv2;
  reg  [15:0] rows [0:19];

  always #5 i_ref_clk = ~i_ref_clk;

  flash_host_model hm (.i_clk(i_ref_clk), .i_dq(dq_w), .o_ce_n(ce_n),
    .o_we_n(we_n), .o_oe_n(oe_n), .o_bus32(bus32), .o_addr(addr),
    .o_dq(h_dq));

  flash_cmd_front i_dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
    .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_bus32(bus32),
    .i_addr(addr), .i_dq(dq_w), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .i_array_data(i_array_data), .i_core_done(i_core_done),
    .i_core_fail(i_core_fail), .o_array_addr(o_array_addr),
    .o_prog_req(o_prog_req), .o_erase_req(o_erase_req),
    .o_suspend_req(o_suspend_req), .o_resume_req(o_resume_req),
    .o_prog_data(o_prog_data), .o_erase_susp(o_erase_susp));

  // array core stand-in: data tracks the requested address
  always @(posedge i_ref_clk) begin
    i_array_data <= {12'hA5C, o_array_addr};
    if (o_erase_req === 1'b1)
      n_erase = n_erase + 1;
    if (o_suspend_req === 1'b1)
      n_susp = n_susp + 1;
    if (o_resume_req === 1'b1)
      n_res = n_res + 1;
    if (o_prog_req === 1'b1) begin
      n_prog = n_prog + 1;
      prog_addr = o_array_addr;
      prog_data = o_prog_data;
    end
  end

  function [31:0] arr(input [19:0] a);
    arr = {12'hA5C, a};
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task core_evt(input fail);
    begin
      @(posedge i_ref_clk);
      i_core_done <= !fail;
      i_core_fail <= fail;
      @(posedge i_ref_clk);
      i_core_done <= 1'b0;
      i_core_fail <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
    end
  endtask

  task unlock;
    begin
      hm.wr(20'h00555, 32'h000000AA);
      hm.wr(20'h002AA, 32'h00000055);
    end
  endtask

  task prog(input [19:0] a, input [31:0] d);
    begin
      unlock;
      hm.wr(20'h00555, 32'h000000A0);
      hm.wr(a, d);
    end
  endtask

  task conclude;
    begin
      $display("counts: %0d checks, %0d mismatches", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
        $display("SIMULATION PASSED");
      end else begin
        $display("SIMULATION FAILED");
      end
      $finish;
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches = mismatches + 1;
    conclude;
  end

  initial begin
    // offset in the high byte, entry value in the low byte
    rows = '{16'h4050, 16'h4152, 16'h4249,
      16'h4602, 16'h4701, 16'h4800, 16'h4906,
      16'h4A1F, 16'h4B01, 16'h4C00, 16'h4DB5,
      16'h4EC5, 16'h4F01, 16'h5001, 16'h5100,
      16'h5702, 16'h580F, 16'h591F, 16'h5A00, 16'h5B00};
    repeat (16) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    hm.rd(20'h12345, rv);
    check(rv, arr(20'h12345));
    $display("test done: power-up read");
    hm.wr(20'h00055, 32'h00000098);
    for (m = 0; m < 2; m = m + 1) begin
      hm.width(m[0]);
      for (i = 0; i < 20; i = i + 1) begin
        hm.rd(m ? {12'h000, rows[i][15:8]}
                : {11'h000, rows[i][15:8], 1'b0}, rv);
        check(rv, {24'h000000, rows[i][7:0]});
      end
    end
    $display("test done: query table");
    hm.wr(20'h00046, 32'h000000FF);
    hm.rd(20'h00046, rv);
    check(rv, arr(20'h00046));
    hm.wr(20'h00055, 32'h00000098);
    hm.rd(20'h00046, rv);
    check(rv, 32'h00000002);
    hm.wr(20'h00000, 32'h000000F0);
    hm.wr(20'h00555, 32'h000000AA);
    hm.wr(20'h002AA, 32'h00000000);
    hm.wr(20'h00555, 32'h000000A0);
    hm.wr(20'h01234, 32'h00005A5A);
    check(n_prog, 0);
    hm.rd(20'h01234, rv);
    check(rv, arr(20'h01234));
    $display("test done: query write and broken sequence");
    prog(20'h01234, 32'hCAFE0012);
    check(n_prog, 1);
    check(prog_addr, 20'h01234);
    check(prog_data, 32'hCAFE0012);
    hm.rd(20'h01234, rv);
    check(rv[7], 1'b1);
    core_evt(1'b0);
    hm.rd(20'h01234, rv);
    check(rv, arr(20'h01234));
    $display("test done: program");
    unlock;
    hm.wr(20'h00555, 32'h00000080);
    unlock;
    hm.wr(20'h08000, 32'h00000030);
    check(n_erase, 1);
    hm.wr(20'h00000, 32'h000000B0);
    check(n_susp, 1);
    check(o_erase_susp, 1'b1);
    hm.rd(20'h10004, rv);
    check(rv, arr(20'h10004));
    hm.rd(20'h08010, rv);
    hm.rd(20'h08010, rv2);
    check(rv[7], 1'b1);
    check(rv[2] ^ rv2[2], 1'b1);
    prog(20'h10020, 32'h00001111);
    check(n_prog, 2);
    core_evt(1'b0);
    hm.rd(20'h08010, rv);
    check(rv[7], 1'b1);
    hm.rd(20'h10020, rv);
    check(rv, arr(20'h10020));
    hm.wr(20'h00000, 32'h00000030);
    check(n_res, 1);
    check(o_erase_susp, 1'b0);
    core_evt(1'b0);
    hm.rd(20'h08010, rv);
    check(rv, arr(20'h08010));
    $display("test done: erase suspend");
    prog(20'h00400, 32'h00000000);
    core_evt(1'b1);
    hm.rd(20'h00400, rv);
    check(rv[5], 1'b1);
    hm.wr(20'h00000, 32'h000000F0);
    hm.rd(20'h00400, rv);
    check(rv, arr(20'h00400));
    $display("test done: failed program");
    // autoselect: an unlock there only drops back to array read
    unlock;
    hm.wr(20'h00555, 32'h00000090);
    prog(20'h00800, 32'h00000077);
    check(n_prog, 3);
    hm.wr(20'h00000, 32'h000000F0);
    prog(20'h00800, 32'h00000077);
    check(n_prog, 4);
    check(prog_addr, 20'h00800);
    core_evt(1'b0);
    $display("test done: autoselect exit");
    // reset in query mode must come back in array read
    hm.wr(20'h00055, 32'h00000098);
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check(o_dq_oe, 1'b0);
    i_resetn <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    hm.rd(20'h00046, rv);
    check(rv, arr(20'h00046));
    $display("test done: reset in query mode");
    conclude;
  end
endmodule // flash_cmd_front_test
